// >>> ppt_timer.sv
// programmable pulse timer channel with an Avalon-MM register slave
// Notes on behaviour
// - square wave, programmable frequency, duty, polarity
// - flip-flop inverts on duty or period match
// - buffered duty loads on period match
// - duty and period registers are 16 bits
// - enable bit 7 turns channel on
// - run bits 2 and 0 start/stop
// - buffering off while initial values written
// - buffered values take effect at match
// - toggle enables and flip-flop initial value
// - mode selects prescaler tap 001 to 111
// - counter clears on period match
// - control field 01 starts on trigger
// - toggle enables 11 invert on each match, hold when both coincide
// - run in trigger mode arms counter
// - run cleared stops and clears counter
// - force field: invert, set, clear
// - stopped counter: compare writes immediate
// - edge select: 0 rising, 1 falling
`timescale 1ns/1ps

module ppt_timer (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic TRIGGER_INPUT_PIN,
	output logic TIMER_OUTPUT_PIN,
	output logic DUTY_MATCH_IRQ,
	output logic PERIOD_MATCH_IRQ
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------

	// prescaler tap: select n ticks once every 2**n clocks, 0 never
	function automatic logic tap_hit(input logic [6:0] p,
		input logic [2:0] sel);
		logic [6:0] m;
		m = 7'h7F >> (3'h7 - sel);
		tap_hit = (sel != 3'h0) && ((p & m) == m);
	endfunction : tap_hit

	ppt_pkg::ppt_state_s s;
	ppt_pkg::ppt_state_s next_s;
	logic running;
	logic ext_mode;
	logic counting;
	logic tick;
	logic m0;
	logic m1;
	logic trig_edge;
	logic acc_wr;
	logic acc_rd;
	logic [15:0] wdata16;

	// ------------------------------------------------------------------
	// bus handshake: one wait cycle, answer on the second
	// ------------------------------------------------------------------
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s.ack;
	assign acc_wr = AVS_WRITE & s.ack;
	assign acc_rd = AVS_READ & s.ack;
	assign wdata16 = AVS_WRITEDATA[15:0];

	// outputs straight from flops
	assign AVS_READDATA = s.rdata;
	assign TIMER_OUTPUT_PIN = s.ff;
	assign DUTY_MATCH_IRQ = s.irq0;
	assign PERIOD_MATCH_IRQ = s.irq1;

	// ------------------------------------------------------------------
	// counting condition and compare matches
	// ------------------------------------------------------------------
	always_comb begin
		running = s.en && (s.run == 2'h3);
		ext_mode = s.ctrl[1:0] == ppt_pkg::TRIG_EXT;
		trig_edge = s.ctrl[ppt_pkg::EDGE_BIT] ?
			(s.trig_q & ~TRIGGER_INPUT_PIN) :
			(~s.trig_q & TRIGGER_INPUT_PIN);
		counting = running && (!ext_mode || s.started);
		tick = counting &&
			tap_hit(s.presc, s.mode[ppt_pkg::CLKSEL_LSB +: 3]);
		m0 = tick && (s.count == s.duty);
		m1 = tick && (s.count == s.period);
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.ack = (AVS_READ | AVS_WRITE) & ~s.ack;
		next_s.trig_q = TRIGGER_INPUT_PIN;
		next_s.presc = s.presc + 7'h01;
		next_s.irq0 = m0;
		next_s.irq1 = m1;

		// counter: stop clears, period match clears, else increment
		if (!running) begin
			next_s.count = 16'h0000;
			next_s.started = 1'b0;
			next_s.presc = 7'h00;
		end else begin
			if (ext_mode && trig_edge)
				next_s.started = 1'b1;
			if (m1 && s.mode[ppt_pkg::CLRE_BIT])
				next_s.count = 16'h0000;
			else if (tick)
				next_s.count = s.count + 16'h0001;
		end

		// buffered compare values move on period match
		if (m1 && s.ctrl[ppt_pkg::DBUF_BIT]) begin
			next_s.duty = s.duty_buf;
			next_s.period = s.period_buf;
		end

		// output flip-flop toggles on one enabled match, holds when both enabled matches coincide
		if ((m0 && s.toggle[ppt_pkg::TEN0_BIT - 2]) ^
			(m1 && s.toggle[ppt_pkg::TEN1_BIT - 2]))
			next_s.ff = ~s.ff;

		// register writes, taken on the answer cycle
		if (acc_wr) begin
			case (AVS_ADDRESS)
			ppt_pkg::OFF_ENABLE: begin
				next_s.en = AVS_WRITEDATA[ppt_pkg::EN_BIT];
			end
			ppt_pkg::OFF_RUN: begin
				next_s.run = {AVS_WRITEDATA[ppt_pkg::RUN_PBIT],
					AVS_WRITEDATA[ppt_pkg::RUN_BIT]};
			end
			ppt_pkg::OFF_CTRL: begin
				next_s.ctrl = AVS_WRITEDATA[7:0];
			end
			ppt_pkg::OFF_MODE: begin
				next_s.mode = AVS_WRITEDATA[7:0];
			end
			ppt_pkg::OFF_TOGGLE: begin
				next_s.toggle = AVS_WRITEDATA[5:2];
				case (AVS_WRITEDATA[1:0])
				ppt_pkg::FF_INV: next_s.ff = ~s.ff;
				ppt_pkg::FF_SET: next_s.ff = 1'b1;
				ppt_pkg::FF_CLR: next_s.ff = 1'b0;
				default: next_s.ff = next_s.ff;
				endcase
			end
			ppt_pkg::OFF_DUTY: begin
				next_s.duty_buf = wdata16;
				if (!(s.ctrl[ppt_pkg::DBUF_BIT] && running))
					next_s.duty = wdata16;
			end
			ppt_pkg::OFF_PERIOD: begin
				next_s.period_buf = wdata16;
				if (!(s.ctrl[ppt_pkg::DBUF_BIT] && running))
					next_s.period = wdata16;
			end
			default: begin
				next_s.rdata = s.rdata; // unmapped: ignored
			end
			endcase
		end

		// register reads, data stands on the answer cycle
		if (next_s.ack && AVS_READ) begin
			case (AVS_ADDRESS)
			ppt_pkg::OFF_ENABLE: next_s.rdata = {24'h000000, s.en, 7'h00};
			ppt_pkg::OFF_RUN: next_s.rdata = {29'h00000000, s.run[1],
				1'b0, s.run[0]};
			ppt_pkg::OFF_CTRL: next_s.rdata = {24'h000000, s.ctrl};
			ppt_pkg::OFF_MODE: next_s.rdata = {24'h000000, s.mode};
			ppt_pkg::OFF_TOGGLE: next_s.rdata = {26'h0000000, s.toggle,
				2'h3};
			ppt_pkg::OFF_DUTY: next_s.rdata = {16'h0000, s.duty};
			ppt_pkg::OFF_PERIOD: next_s.rdata = {16'h0000, s.period};
			ppt_pkg::OFF_COUNT: next_s.rdata = {16'h0000, s.count};
			ppt_pkg::OFF_STATUS: next_s.rdata = {29'h00000000, running,
				s.started, s.ff};
			default: next_s.rdata = 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			s <= '0;
			s.ctrl <= ppt_pkg::RST_CTRL;
			s.mode <= ppt_pkg::RST_MODE;
			s.toggle <= ppt_pkg::RST_TOGGLE;
			s.duty <= ppt_pkg::RST_CMP;
			s.period <= ppt_pkg::RST_CMP;
			s.ff <= ppt_pkg::RST_FF;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);

	property p_stop_clears;
		!running |=> s.count == 16'h0000;
	endproperty
	a_stop_clears: assert property (p_stop_clears)
		else $error("counter not cleared while stopped");

	property p_period_clear;
		m1 && s.mode[3] |=> s.count == 16'h0000;
	endproperty
	a_period_clear: assert property (p_period_clear)
		else $error("counter not cleared on period match");

	property p_increment;
		tick && !(m1 && s.mode[3]) |=> s.count == $past(s.count) + 16'h1;
	endproperty
	a_increment: assert property (p_increment)
		else $error("counter did not step by one");

	property p_toggle;
		(m0 && s.toggle[0]) && !(m1 && s.toggle[1]) && !acc_wr
			|=> s.ff != $past(s.ff);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("flip-flop did not invert on duty match");

	property p_dbuf_load;
		m1 && s.ctrl[7] && !acc_wr |=> s.duty == $past(s.duty_buf);
	endproperty
	a_dbuf_load: assert property (p_dbuf_load)
		else $error("buffered duty not loaded on period match");

	property p_irq_pulse;
		m0 |=> DUTY_MATCH_IRQ ##1 !DUTY_MATCH_IRQ || $past(m0);
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("duty match interrupt not one cycle");

	property p_armed_wait;
		running && ext_mode && !s.started |=> s.count == 16'h0000;
	endproperty
	a_armed_wait: assert property (p_armed_wait)
		else $error("counter moved before trigger");

	property p_force_set;
		acc_wr && AVS_ADDRESS == 6'h10 && AVS_WRITEDATA[1:0] == 2'h1
			|=> TIMER_OUTPUT_PIN;
	endproperty
	a_force_set: assert property (p_force_set)
		else $error("force set did not set the flip-flop");

	property p_wait_one;
		(AVS_READ || AVS_WRITE) && !s.ack
			|-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("bus answer not on second cycle");

	property p_immediate;
		acc_wr && AVS_ADDRESS == 6'h14 && !running
			|=> s.duty == $past(wdata16);
	endproperty
	a_immediate: assert property (p_immediate)
		else $error("stopped duty write not immediate");

	property p_period_toggle;
		(m1 && s.toggle[1]) && !(m0 && s.toggle[0]) && !acc_wr
			|=> s.ff != $past(s.ff);
	endproperty
	a_period_toggle: assert property (p_period_toggle)
		else $error("flip-flop did not invert on period match");

	property p_dbuf_hold;
		acc_wr && AVS_ADDRESS == ppt_pkg::OFF_DUTY && running &&
			s.ctrl[ppt_pkg::DBUF_BIT] && !m1 |=> s.duty == $past(s.duty);
	endproperty
	a_dbuf_hold: assert property (p_dbuf_hold)
		else $error("buffered duty write took effect early");

	property p_read_data;
		acc_rd && AVS_ADDRESS == ppt_pkg::OFF_DUTY
			|-> AVS_READDATA == {16'h0000, $past(s.duty)};
	endproperty
	a_read_data: assert property (p_read_data)
		else $error("duty read did not return the active value");

	// main scenarios seen at least once
	c_period: cover property (m1 ##[1:300] m1);
	c_trigger: cover property (ext_mode && trig_edge && running);
	c_dbuf: cover property (m1 && s.ctrl[7]);
	c_oneshot: cover property (ext_mode && m0);
	c_force: cover property (acc_wr && AVS_ADDRESS == ppt_pkg::OFF_TOGGLE);

endmodule : ppt_timer

// >>> ppt_pkg.sv
// package with register map, field positions and state for the pulse timer
package ppt_pkg;

	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [5:0] OFF_ENABLE = 6'h00; // channel_enable_reg
	localparam logic [5:0] OFF_RUN = 6'h04; // run_control_reg
	localparam logic [5:0] OFF_CTRL = 6'h08; // channel_control_reg
	localparam logic [5:0] OFF_MODE = 6'h0C; // count_mode_reg
	localparam logic [5:0] OFF_TOGGLE = 6'h10; // toggle_control_reg
	localparam logic [5:0] OFF_DUTY = 6'h14; // duty_compare_reg
	localparam logic [5:0] OFF_PERIOD = 6'h18; // period_compare_reg
	localparam logic [5:0] OFF_COUNT = 6'h1C; // up_counter, read only
	localparam logic [5:0] OFF_STATUS = 6'h20; // flip-flop and trigger state

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int EN_BIT = 7; // channel enable
	localparam int RUN_BIT = 0; // count_run_bit
	localparam int RUN_PBIT = 2; // companion run bit
	localparam int DBUF_BIT = 7; // double_buffer_en
	localparam int EDGE_BIT = 6; // trigger_edge_sel
	localparam logic [1:0] TRIG_EXT = 2'h1; // external trigger start
	localparam int CLKSEL_LSB = 0; // 3-bit clock select
	localparam int CLRE_BIT = 3; // clear on period match
	localparam int TEN0_BIT = 2; // duty_match_toggle_en
	localparam int TEN1_BIT = 3; // period_match_toggle_en
	localparam logic [1:0] FF_INV = 2'h0;
	localparam logic [1:0] FF_SET = 2'h1;
	localparam logic [1:0] FF_CLR = 2'h2;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [3:0] RST_TOGGLE = 4'h0;
	localparam logic [15:0] RST_CMP = 16'h0000;
	localparam logic RST_FF = 1'b0; // undefined in hardware, zero here

	// ------------------------------------------------------------------
	// state of the whole block
	// ------------------------------------------------------------------
	typedef struct packed {
		logic ack; // bus answer cycle
		logic [31:0] rdata;
		logic en;
		logic [1:0] run; // {companion, run}
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [3:0] toggle; // toggle control bits 5:2
		logic [15:0] duty;
		logic [15:0] period;
		logic [15:0] duty_buf;
		logic [15:0] period_buf;
		logic [15:0] count;
		logic [6:0] presc;
		logic ff;
		logic started; // trigger seen in external mode
		logic trig_q; // previous trigger level
		logic irq0;
		logic irq1;
	} ppt_state_s;

endpackage : ppt_pkg

// >>> ppt_load.sv
// partner model: load on the timer output pin and trigger source
`timescale 1ns/1ps
module ppt_load (
	input wire logic clk,
	input wire logic pin,
	output logic trig
);
	// ------------------------------------------------------------
	// trigger source and output observer
	// ------------------------------------------------------------
	int edges = 0;
	logic pin_q = 1'b0;
	initial trig = 1'b0;
	// changes the trigger level just after a rising edge
	task drive(input logic v);
		@(posedge clk);
		trig <= v;
	endtask : drive
	// counts transitions of the output seen by the load
	always @(posedge clk) begin
		if (pin !== pin_q)
			edges <= edges + 1;
		pin_q <= pin;
	end
endmodule : ppt_load

// >>> ppt_timer_test.sv
// self-checking testbench for the pulse timer channel
`timescale 1ns/1ps
module ppt_timer_test;
	// ------------------------------------------------------------
	// signals and tables
	// ------------------------------------------------------------
	logic CLK_SYS = 1'b0;
	logic ARST_N = 1'b0;
	logic [5:0] AVS_ADDRESS = 6'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic TRIGGER_INPUT_PIN;
	logic TIMER_OUTPUT_PIN;
	logic DUTY_MATCH_IRQ;
	logic PERIOD_MATCH_IRQ;
	int bad_count = 0;
	int n_checks = 0;
	int cyc;
	logic [31:0] rv;
	logic p;
	typedef struct packed {logic [5:0] a; logic [31:0] e;} ppt_row_s;
	ppt_row_s rows [10] = '{'{ppt_pkg::OFF_ENABLE, 32'h0},
		'{ppt_pkg::OFF_RUN, 32'h0}, '{ppt_pkg::OFF_CTRL, 32'h0},
		'{ppt_pkg::OFF_MODE, 32'h0}, '{ppt_pkg::OFF_TOGGLE, 32'h3},
		'{ppt_pkg::OFF_DUTY, 32'h0}, '{ppt_pkg::OFF_PERIOD, 32'h0},
		'{ppt_pkg::OFF_COUNT, 32'h0}, '{ppt_pkg::OFF_STATUS, 32'h0},
		'{6'h3C, 32'h0}};
	logic [1:0] fv [3] = '{ppt_pkg::FF_SET, ppt_pkg::FF_CLR, ppt_pkg::FF_INV};
	logic fx [3] = '{1'b1, 1'b0, 1'b1};

	always #12.5 CLK_SYS = ~CLK_SYS;

	ppt_timer ppt_timer_inst (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.TRIGGER_INPUT_PIN(TRIGGER_INPUT_PIN),
		.TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
		.DUTY_MATCH_IRQ(DUTY_MATCH_IRQ), .PERIOD_MATCH_IRQ(PERIOD_MATCH_IRQ));
	ppt_load ppt_load_inst (.clk(CLK_SYS), .pin(TIMER_OUTPUT_PIN),
		.trig(TRIGGER_INPUT_PIN));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask : chk
	// one bus access: raised just after an edge, held until the rising
	// edge at which waitrequest is seen low, read data taken at that edge
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		do
			@(posedge CLK_SYS);
		while (AVS_WAITREQUEST !== 1'b0);
		rv = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask : bus
	task rd(input logic [5:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		chk(n, rv, e);
	endtask : rd
	// waits for a match pulse; e above zero is the expected spacing
	task wirq(input logic per, input int e, input string n);
		cyc = 0;
		do begin
			@(negedge CLK_SYS);
			cyc++;
		end while ((per ? PERIOD_MATCH_IRQ : DUTY_MATCH_IRQ) !== 1'b1
			&& cyc < 40);
		if (e > 0)
			chk(n, cyc, e);
		else
			chk(n, cyc < 40, 1);
	endtask : wirq
	task complete_run;
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge CLK_SYS);
		ARST_N <= 1'b1;
		foreach (rows[i])
			rd(rows[i].a, rows[i].e, "reset value");
		bus(1'b1, ppt_pkg::OFF_ENABLE, 32'h80);
		bus(1'b1, ppt_pkg::OFF_RUN, 32'h0);
		bus(1'b1, ppt_pkg::OFF_CTRL, 32'h0);
		bus(1'b1, ppt_pkg::OFF_DUTY, 32'h1);
		bus(1'b1, ppt_pkg::OFF_PERIOD, 32'h3);
		bus(1'b1, ppt_pkg::OFF_TOGGLE, 32'hE);
		bus(1'b1, ppt_pkg::OFF_MODE, 32'h9);
		bus(1'b1, ppt_pkg::OFF_RUN, 32'h5);
		wirq(1'b1, 0, "first period match");
		p = TIMER_OUTPUT_PIN;
		wirq(1'b0, 4, "period to duty");
		chk("pin at duty", TIMER_OUTPUT_PIN, !p);
		wirq(1'b1, 4, "duty to period");
		chk("pin at period", TIMER_OUTPUT_PIN, p);
		wirq(1'b1, 8, "cycle length");
		bus(1'b1, ppt_pkg::OFF_RUN, 32'h0);
		rd(ppt_pkg::OFF_COUNT, 32'h0, "stopped count");
		// forced flip-flop values while stopped
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, ppt_pkg::OFF_TOGGLE, {28'h0, 2'h3, fv[i]});
			@(negedge CLK_SYS);
			chk("forced pin", TIMER_OUTPUT_PIN, fx[i]);
		end
		bus(1'b1, ppt_pkg::OFF_TOGGLE, 32'hE);
		// double-buffered duty
		bus(1'b1, ppt_pkg::OFF_CTRL, 32'h80);
		bus(1'b1, ppt_pkg::OFF_DUTY, 32'h2);
		rd(ppt_pkg::OFF_DUTY, 32'h2, "stopped duty write");
		bus(1'b1, ppt_pkg::OFF_RUN, 32'h5);
		wirq(1'b1, 0, "buffered start");
		bus(1'b1, ppt_pkg::OFF_DUTY, 32'h1);
		rd(ppt_pkg::OFF_DUTY, 32'h2, "duty before reload");
		wirq(1'b1, 0, "reload match");
		wirq(1'b0, 4, "reloaded duty");
		// one-shot on a rising trigger: delay 2 ticks, width 3 ticks
		bus(1'b1, ppt_pkg::OFF_RUN, 32'h0);
		bus(1'b1, ppt_pkg::OFF_CTRL, 32'h01);
		bus(1'b1, ppt_pkg::OFF_DUTY, 32'h2);
		bus(1'b1, ppt_pkg::OFF_PERIOD, 32'h5);
		bus(1'b1, ppt_pkg::OFF_TOGGLE, 32'hE);
		bus(1'b1, ppt_pkg::OFF_RUN, 32'h5);
		repeat (20) @(posedge CLK_SYS);
		rd(ppt_pkg::OFF_COUNT, 32'h0, "armed count");
		ppt_load_inst.drive(1'b1);
		wirq(1'b0, 0, "rising trigger");
		chk("one-shot pin", TIMER_OUTPUT_PIN, 1'b1);
		wirq(1'b1, 6, "pulse width");
		chk("one-shot end", TIMER_OUTPUT_PIN, 1'b0);
		bus(1'b1, ppt_pkg::OFF_RUN, 32'h0);
		// falling edge selected, flip-flop cleared first
		bus(1'b1, ppt_pkg::OFF_CTRL, 32'h41);
		bus(1'b1, ppt_pkg::OFF_TOGGLE, 32'hE);
		bus(1'b1, ppt_pkg::OFF_RUN, 32'h5);
		repeat (20) @(posedge CLK_SYS);
		rd(ppt_pkg::OFF_COUNT, 32'h0, "high trigger count");
		ppt_load_inst.drive(1'b0);
		wirq(1'b0, 0, "falling trigger");
		chk("falling pin", TIMER_OUTPUT_PIN, 1'b1);
		chk("load edges", ppt_load_inst.edges != 0, 1);
		// reset in mid-run: pin low at once, registers back to reset
		@(posedge CLK_SYS);
		ARST_N <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		chk("pin in reset", TIMER_OUTPUT_PIN, 1'b0);
		ARST_N <= 1'b1;
		foreach (rows[i])
			rd(rows[i].a, rows[i].e, "value after reset");
		// channel disabled: no counting until the enable bit is set
		bus(1'b1, ppt_pkg::OFF_PERIOD, 32'h3);
		bus(1'b1, ppt_pkg::OFF_MODE, 32'hA);
		bus(1'b1, ppt_pkg::OFF_RUN, 32'h5);
		repeat (20) @(posedge CLK_SYS);
		rd(ppt_pkg::OFF_STATUS, 32'h0, "disabled status");
		rd(ppt_pkg::OFF_COUNT, 32'h0, "disabled count");
		bus(1'b1, ppt_pkg::OFF_ENABLE, 32'h80);
		rd(ppt_pkg::OFF_STATUS, 32'h4, "enabled status");
		// clock select 2: one tick every four clocks, four ticks a cycle
		wirq(1'b1, 0, "slow period");
		wirq(1'b1, 16, "slow cycle");
		complete_run;
	end

	// watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge CLK_SYS);
		bad_count++;
		complete_run;
	end
endmodule : ppt_timer_test
